/* hdl/srls_pkg.sv */
// Package with opcodes, latency codes and table constants for the read latency selector
package srls_pkg;

    // Latency code values
    localparam logic [1:0] SRLS_CODE_00 = 2'h0;
    localparam logic [1:0] SRLS_CODE_01 = 2'h1;
    localparam logic [1:0] SRLS_CODE_10 = 2'h2;
    localparam logic [1:0] SRLS_CODE_11 = 2'h3;

    // Serial clock limits per row, in MHz
    localparam logic [7:0] SRLS_FREQ_ROW2 = 8'h32;
    localparam logic [7:0] SRLS_FREQ_ROW3 = 8'h50;
    localparam logic [7:0] SRLS_FREQ_ROW4 = 8'h5a;
    localparam logic [7:0] SRLS_FREQ_ROW5 = 8'h68;
    localparam logic [7:0] SRLS_FREQ_ROW6 = 8'h85;

    // Cycle counts
    localparam logic [7:0] SRLS_NOT_SUPP = 8'hff;
    localparam logic [7:0] SRLS_CYC_0    = 8'h00;
    localparam logic [7:0] SRLS_CYC_1    = 8'h01;
    localparam logic [7:0] SRLS_CYC_2    = 8'h02;
    localparam logic [7:0] SRLS_CYC_4    = 8'h04;
    localparam logic [7:0] SRLS_CYC_5    = 8'h05;
    localparam logic [7:0] SRLS_CYC_6    = 8'h06;
    localparam logic [7:0] SRLS_CYC_8    = 8'h08;

    // Opcodes, three- and four-byte address forms
    localparam logic [7:0] SRLS_OP_READ3  = 8'h03;
    localparam logic [7:0] SRLS_OP_READ4  = 8'h13;
    localparam logic [7:0] SRLS_OP_FAST3  = 8'h0b;
    localparam logic [7:0] SRLS_OP_FAST4  = 8'h0c;
    localparam logic [7:0] SRLS_OP_DOUT3  = 8'h3b;
    localparam logic [7:0] SRLS_OP_DOUT4  = 8'h3c;
    localparam logic [7:0] SRLS_OP_QOUT3  = 8'h6b;
    localparam logic [7:0] SRLS_OP_QOUT4  = 8'h6c;
    localparam logic [7:0] SRLS_OP_DIO3   = 8'hbb;
    localparam logic [7:0] SRLS_OP_DIO4   = 8'hbc;
    localparam logic [7:0] SRLS_OP_QIO3   = 8'heb;
    localparam logic [7:0] SRLS_OP_QIO4   = 8'hec;

    // Reset values of the outputs
    localparam logic [7:0] SRLS_RST_CYC   = 8'hff;

    typedef enum logic [2:0] {
        SRLS_RD_NORMAL,
        SRLS_RD_FAST,
        SRLS_RD_DOUT,
        SRLS_RD_QOUT,
        SRLS_RD_DIO,
        SRLS_RD_QIO,
        SRLS_RD_NONE
    } srls_kind_t;

endpackage : srls_pkg

/* hdl/srls_table.sv */
// Combinational latency code table: mode and dummy cycles per row and command kind
`timescale 1ns/1ps
`default_nettype none
module srls_table (
    // Lookup
    input  wire logic [1:0]          code_in,
    input  wire logic                fast_row_in,
    input  wire srls_pkg::srls_kind_t kind_in,
    // Result
    output logic [7:0]               mode_out,
    output logic [7:0]               dummy_out
);
    import srls_pkg::*;

    always_comb begin
        mode_out  = SRLS_NOT_SUPP;
        dummy_out = SRLS_NOT_SUPP;
        if (fast_row_in) begin
            // Highest frequency row: only fast read survives
            if (kind_in == SRLS_RD_FAST) begin
                mode_out  = SRLS_CYC_0;
                dummy_out = SRLS_CYC_8;
            end
        end else begin
            unique case (kind_in)
                SRLS_RD_NORMAL: begin
                    if (code_in == SRLS_CODE_11) begin
                        mode_out  = SRLS_CYC_0;
                        dummy_out = SRLS_CYC_0;
                    end
                end
                SRLS_RD_FAST, SRLS_RD_DOUT, SRLS_RD_QOUT: begin
                    mode_out  = SRLS_CYC_0;
                    dummy_out = (code_in == SRLS_CODE_11) ? SRLS_CYC_0 : SRLS_CYC_8;
                end
                SRLS_RD_DIO: begin
                    mode_out = SRLS_CYC_0;
                    unique case (code_in)
                        SRLS_CODE_11: dummy_out = SRLS_CYC_4;
                        SRLS_CODE_00: dummy_out = SRLS_CYC_4;
                        SRLS_CODE_01: dummy_out = SRLS_CYC_5;
                        SRLS_CODE_10: dummy_out = SRLS_CYC_6;
                    endcase
                end
                SRLS_RD_QIO: begin
                    mode_out = SRLS_CYC_2;
                    unique case (code_in)
                        SRLS_CODE_11: dummy_out = SRLS_CYC_1;
                        SRLS_CODE_00: dummy_out = SRLS_CYC_4;
                        SRLS_CODE_01: dummy_out = SRLS_CYC_4;
                        SRLS_CODE_10: dummy_out = SRLS_CYC_5;
                    endcase
                end
                SRLS_RD_NONE: begin
                    mode_out  = SRLS_NOT_SUPP;
                    dummy_out = SRLS_NOT_SUPP;
                end
                default: begin
                    mode_out  = SRLS_NOT_SUPP;
                    dummy_out = SRLS_NOT_SUPP;
                end
            endcase
        end
    end

endmodule : srls_table
`default_nettype wire

/* hdl/srls_sdr_read_latency_selector.sv */
// Top of the read latency selector: decodes opcode, looks up cycles, registers result
// How it works
// - Code 11b, up to 50 MHz: plain, fast, dual and quad out need no extra cycles.
// - Code 11b: dual I/O four dummy; quad I/O two mode, one dummy.
// - Code 00b, up to 80 MHz: fast, dual and quad out take eight dummy.
// - Code 00b: dual I/O four dummy; quad I/O two mode, four dummy.
// - Code 01b, 90 MHz: eight dummy; dual I/O five; quad I/O two plus four.
// - Code 10b, 104 MHz: eight dummy; dual I/O six; quad I/O two plus five.
// - Code 10b at 133 MHz: only fast read, eight dummy cycles.
// - Plain read unsupported above 50 MHz; FFh marks any unsupported entry.
// - Quad I/O in the 133 MHz row reports FFh for mode and dummy.
// - Opcodes 03/13, 0B/0C, 3B/3C, 6B/6C, BB/BC, EB/EC; second takes four bytes.
`timescale 1ns/1ps
`default_nettype none
module srls_sdr_read_latency_selector (
    // Clock and reset
    input  wire logic        clock_in,
    input  wire logic        sys_rst_in,
    // Configuration
    input  wire logic [1:0]  latency_code_in,
    input  wire logic        high_freq_in,
    // Command
    input  wire logic        cmd_valid_in,
    input  wire logic [7:0]  opcode_in,
    // Result
    output logic             result_valid_out,
    output logic             read_cmd_out,
    output logic             addr4_out,
    output logic             supported_out,
    output logic [7:0]       mode_cycles_out,
    output logic [7:0]       dummy_cycles_out,
    output logic [7:0]       freq_limit_out
);
    import srls_pkg::*;

    // Maps an opcode to its read kind
    function automatic srls_kind_t decode_kind(input logic [7:0] op);
        unique case (op)
            SRLS_OP_READ3, SRLS_OP_READ4: decode_kind = SRLS_RD_NORMAL;
            SRLS_OP_FAST3, SRLS_OP_FAST4: decode_kind = SRLS_RD_FAST;
            SRLS_OP_DOUT3, SRLS_OP_DOUT4: decode_kind = SRLS_RD_DOUT;
            SRLS_OP_QOUT3, SRLS_OP_QOUT4: decode_kind = SRLS_RD_QOUT;
            SRLS_OP_DIO3,  SRLS_OP_DIO4:  decode_kind = SRLS_RD_DIO;
            SRLS_OP_QIO3,  SRLS_OP_QIO4:  decode_kind = SRLS_RD_QIO;
            default:                      decode_kind = SRLS_RD_NONE;
        endcase
    endfunction : decode_kind

    // Four-byte address forms
    function automatic logic is_addr4(input logic [7:0] op);
        is_addr4 = (op == SRLS_OP_READ4) || (op == SRLS_OP_FAST4) || (op == SRLS_OP_DOUT4)
                || (op == SRLS_OP_QOUT4) || (op == SRLS_OP_DIO4) || (op == SRLS_OP_QIO4);
    endfunction : is_addr4

    srls_kind_t  kind;
    logic [7:0]  tab_mode;
    logic [7:0]  tab_dummy;
    logic        fast_row;
    logic [7:0]  freq_next;

    assign kind = decode_kind(opcode_in);
    // The 133 MHz row exists only under code 10b
    assign fast_row = high_freq_in && (latency_code_in == SRLS_CODE_10);

    srls_table u_table (
        .code_in     (latency_code_in),
        .fast_row_in (fast_row),
        .kind_in     (kind),
        .mode_out    (tab_mode),
        .dummy_out   (tab_dummy)
    );

    always_comb begin
        unique case (latency_code_in)
            SRLS_CODE_11: freq_next = SRLS_FREQ_ROW2;
            SRLS_CODE_00: freq_next = SRLS_FREQ_ROW3;
            SRLS_CODE_01: freq_next = SRLS_FREQ_ROW4;
            SRLS_CODE_10: freq_next = fast_row ? SRLS_FREQ_ROW6 : SRLS_FREQ_ROW5;
        endcase
    end

    // Handshake flag: one-cycle pulse per accepted command
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            result_valid_out <= 1'b0;
        end else begin
            result_valid_out <= cmd_valid_in;
        end
    end

    // Result fields hold until the next command
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            read_cmd_out     <= 1'b0;
            addr4_out        <= 1'b0;
            supported_out    <= 1'b0;
            mode_cycles_out  <= SRLS_RST_CYC;
            dummy_cycles_out <= SRLS_RST_CYC;
        end else if (cmd_valid_in) begin
            read_cmd_out     <= (kind != SRLS_RD_NONE);
            addr4_out        <= is_addr4(opcode_in);
            // FFh in either count means unsupported at this frequency
            supported_out    <= (tab_mode != SRLS_NOT_SUPP) && (tab_dummy != SRLS_NOT_SUPP);
            mode_cycles_out  <= tab_mode;
            dummy_cycles_out <= tab_dummy;
        end
    end

    // Clock limit follows the configuration continuously
    always_ff @(posedge clock_in) begin
        if (sys_rst_in) begin
            freq_limit_out <= SRLS_FREQ_ROW2;
        end else begin
            freq_limit_out <= freq_next;
        end
    end

endmodule : srls_sdr_read_latency_selector
`default_nettype wire

/* tb/srls_host_model.sv */
// Host model: issues read opcodes on falling edges
`timescale 1ns/1ps
`default_nettype none
module srls_host_model (
    // Clock
    input  wire logic  clock_in,
    // Command
    output logic       cmd_valid_out,
    output logic [7:0] opcode_out
);
    initial begin
        cmd_valid_out = 1'b0;
        opcode_out    = 8'h00;
    end
    // One or two back-to-back opcodes; the bus shows junk once released
    task automatic issue(input logic [7:0] op_a, input logic [7:0] op_b, input logic two);
        @(negedge clock_in);
        cmd_valid_out = 1'b1;
        opcode_out    = op_a;
        if (two) begin
            @(negedge clock_in);
            opcode_out = op_b;
        end
        @(negedge clock_in);
        cmd_valid_out = 1'b0;
        opcode_out    = ~opcode_out;
    endtask : issue
endmodule : srls_host_model
`default_nettype wire

/* tb/srls_sdr_asserts.sv */
// Checker: answer timing and table relations at the selector ports
`timescale 1ns/1ps
`default_nettype none
module srls_sdr_asserts (
    input wire logic       clock_in,
    input wire logic       sys_rst_in,
    input wire logic [1:0] latency_code_in,
    input wire logic       high_freq_in,
    input wire logic       cmd_valid_in,
    input wire logic [7:0] opcode_in,
    input wire logic       result_valid_out,
    input wire logic       read_cmd_out,
    input wire logic       addr4_out,
    input wire logic       supported_out,
    input wire logic [7:0] mode_cycles_out,
    input wire logic [7:0] dummy_cycles_out,
    input wire logic [7:0] freq_limit_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_take;
        cmd_valid_in;
    endsequence
    sequence s_ff;
        mode_cycles_out == 8'hff && dummy_cycles_out == 8'hff;
    endsequence
    a_answer_next: assert property (s_take |=> result_valid_out) else $error("late");
    a_no_extra: assert property (!cmd_valid_in |=> !result_valid_out) else $error("extra");
    a_supp_flag: assert property (result_valid_out |-> supported_out ==
        (mode_cycles_out != 8'hff && dummy_cycles_out != 8'hff)) else $error("flag");
    a_qio_fast: assert property (s_take ##0 (opcode_in == 8'heb && latency_code_in == 2'h3)
        |=> mode_cycles_out == 8'h02 && dummy_cycles_out == 8'h01) else $error("qio");
    a_plain_unsupp: assert property (s_take ##0 (opcode_in inside {8'h03, 8'h13}
        && latency_code_in != 2'h3) |=> s_ff) else $error("plain");
    a_top_row: assert property (s_take ##0 (latency_code_in == 2'h2 && high_freq_in
        && opcode_in inside {8'heb, 8'hec}) |=> s_ff) else $error("top row");
    a_addr_width: assert property (s_take |=> addr4_out ==
        ($past(opcode_in) inside {8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc, 8'hec})) else $error("a4");
    a_freq_code00: assert property (latency_code_in == 2'h0 |=> freq_limit_out == 8'h50)
        else $error("freq");
endmodule : srls_sdr_asserts
`default_nettype wire

/* tb/tb.sv */
// Testbench: table rows, reset values, back-to-back and non-read opcodes
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic         clock_in, sys_rst_in, high_freq_in, cmd_valid_in;
    logic         result_valid_out, read_cmd_out, addr4_out, supported_out;
    logic [1:0]   latency_code_in;
    logic [7:0]   opcode_in, mode_cycles_out, dummy_cycles_out, freq_limit_out, fx;
    logic [95:0]  cyc;
    logic [15:0]  exp;
    int           num_errors = 0;
    int           n_compared = 0;
    // Code, top row, clock limit, mode/dummy of plain, fast, dout, qout, dio, qio
    logic [106:0] rows [5] = '{{2'h3, 1'h0, 8'h32, 96'h0000_0000_0000_0000_0004_0201},
        {2'h0, 1'h0, 8'h50, 96'hffff_0008_0008_0008_0004_0204},
        {2'h1, 1'h0, 8'h5a, 96'hffff_0008_0008_0008_0005_0204},
        {2'h2, 1'h0, 8'h68, 96'hffff_0008_0008_0008_0006_0205},
        {2'h2, 1'h1, 8'h85, 96'hffff_0008_ffff_ffff_ffff_ffff}};
    logic [7:0]   ops [12] = '{8'h03, 8'h13, 8'h0b, 8'h0c, 8'h3b, 8'h3c,
        8'h6b, 8'h6c, 8'hbb, 8'hbc, 8'heb, 8'hec};
    srls_sdr_read_latency_selector uut (.clock_in(clock_in), .sys_rst_in(sys_rst_in),
        .latency_code_in(latency_code_in), .high_freq_in(high_freq_in),
        .cmd_valid_in(cmd_valid_in), .opcode_in(opcode_in), .result_valid_out(result_valid_out),
        .read_cmd_out(read_cmd_out), .addr4_out(addr4_out), .supported_out(supported_out),
        .mode_cycles_out(mode_cycles_out), .dummy_cycles_out(dummy_cycles_out),
        .freq_limit_out(freq_limit_out));
    srls_host_model host (.clock_in(clock_in), .cmd_valid_out(cmd_valid_in),
        .opcode_out(opcode_in));
    task automatic chk(input logic [7:0] seen, input logic [7:0] want);
        n_compared++;
        if (seen !== want) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, want);
        end
    endtask : chk
    task automatic wrap_up();
        $display("errors=%0d compared=%0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end
    initial begin
        #20000;
        num_errors++;
        wrap_up();
    end
    initial begin
        sys_rst_in      = 1'b1;
        // Code 00b during reset so the reset limit differs from the configured one
        latency_code_in = 2'h0;
        high_freq_in    = 1'b0;
        repeat (8) @(negedge clock_in);
        chk(mode_cycles_out, 8'hff);
        chk(dummy_cycles_out, 8'hff);
        chk({7'h0, supported_out}, 8'h00);
        chk({7'h0, result_valid_out}, 8'h00);
        chk({7'h0, read_cmd_out}, 8'h00);
        chk({7'h0, addr4_out}, 8'h00);
        chk(freq_limit_out, 8'h32);
        sys_rst_in = 1'b0;
        foreach (rows[r]) begin
            {latency_code_in, high_freq_in, fx, cyc} = rows[r];
            repeat (2) @(negedge clock_in);
            chk(freq_limit_out, fx);
            for (int k = 0; k < 12; k++) begin
                host.issue(ops[k], 8'h00, 1'b0);
                exp = cyc[95 - 16 * (k / 2) -: 16];
                chk({7'h0, result_valid_out}, 8'h01);
                chk({7'h0, read_cmd_out}, 8'h01);
                chk({7'h0, addr4_out}, 8'(k % 2));
                chk(mode_cycles_out, exp[15:8]);
                chk(dummy_cycles_out, exp[7:0]);
                chk({7'h0, supported_out}, {7'h0, exp != 16'hffff});
            end
        end
        host.issue(8'h05, 8'h00, 1'b0);
        chk({7'h0, result_valid_out}, 8'h01);
        chk({7'h0, read_cmd_out}, 8'h00);
        chk({7'h0, supported_out}, 8'h00);
        chk(mode_cycles_out, 8'hff);
        chk(dummy_cycles_out, 8'hff);
        latency_code_in = 2'h3;
        fork
            host.issue(8'heb, 8'hbc, 1'b1);
            begin
                // First opcode is answered one negedge after it is raised
                repeat (2) @(negedge clock_in);
                chk({7'h0, result_valid_out}, 8'h01);
                chk(mode_cycles_out, 8'h02);
                chk(dummy_cycles_out, 8'h01);
                @(negedge clock_in);
                chk({7'h0, result_valid_out}, 8'h01);
                chk(mode_cycles_out, 8'h00);
                chk(dummy_cycles_out, 8'h04);
                chk({7'h0, addr4_out}, 8'h01);
            end
        join
        // Reset in mid-run must drop the held result
        latency_code_in = 2'h0;
        sys_rst_in      = 1'b1;
        @(negedge clock_in);
        chk({7'h0, supported_out}, 8'h00);
        chk({7'h0, result_valid_out}, 8'h00);
        chk({7'h0, read_cmd_out}, 8'h00);
        chk({7'h0, addr4_out}, 8'h00);
        chk(mode_cycles_out, 8'hff);
        chk(dummy_cycles_out, 8'hff);
        chk(freq_limit_out, 8'h32);
        sys_rst_in = 1'b0;
        // First command right after release
        host.issue(8'hec, 8'h00, 1'b0);
        chk({7'h0, result_valid_out}, 8'h01);
        chk({7'h0, addr4_out}, 8'h01);
        chk(mode_cycles_out, 8'h02);
        chk(dummy_cycles_out, 8'h04);
        chk(freq_limit_out, 8'h50);
        wrap_up();
    end
endmodule : tb
bind srls_sdr_read_latency_selector srls_sdr_asserts u_chk (.clock_in(clock_in),
    .sys_rst_in(sys_rst_in), .latency_code_in(latency_code_in), .high_freq_in(high_freq_in),
    .cmd_valid_in(cmd_valid_in), .opcode_in(opcode_in), .result_valid_out(result_valid_out),
    .read_cmd_out(read_cmd_out), .addr4_out(addr4_out), .supported_out(supported_out),
    .mode_cycles_out(mode_cycles_out), .dummy_cycles_out(dummy_cycles_out),
    .freq_limit_out(freq_limit_out));
`default_nettype wire
